//--- pbp_dev.sv
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module pbp_dev
    import pbp_pkg::*;
#(
    parameter int NPAGES = PAGES,
    parameter int EP_CYCLES = EP_CYC,
    parameter int P_CYCLES = P_CYC,
    parameter int BP_CYCLES = BP_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Serial link
    pbp_link_if.dev LINK,
    // Configuration
    input wire logic PAGE_256,
    // Array inspection port
    input wire logic [$clog2(NPAGES*PAGE_BIG)-1:0] MEM_ADDR,
    output logic [7:0] MEM_DATA,
    // Status
    output logic BUSY,
    output logic FAIL
);
    localparam int MAW = $clog2(NPAGES * PAGE_BIG); // Array address width

    // Whole state of the sequencer
    typedef struct packed {
        logic [2:0] sck_s; // Link clock synchroniser
        logic [2:0] cs_s; // Chip select synchroniser
        logic [2:0] si_s; // Data synchroniser
        logic sck_l; // Filtered link clock level
        logic cs_l; // Filtered chip select level
        pbp_rx_t rx; // Command receive phase
        logic [7:0] sh; // Incoming byte
        logic [2:0] bitc; // Bits of current byte
        logic [1:0] abyte; // Address bytes taken
        logic [7:0] opc; // Latched opcode
        logic [23:0] addr; // Latched address bytes
        logic [8:0] boff; // Buffer write offset
        logic [9:0] nbytes; // Data bytes taken, saturating
        logic [PAGE_BIG-1:0] wmask; // Bytes streamed by a partial program
        pbp_run_t run; // Internal operation phase
        logic [8:0] idx; // Byte being programmed
        logic [31:0] wait_c; // Remaining self-timed cycles
        logic erase; // Operation erases first
        logic partial; // Only streamed bytes are programmed
        logic bsel; // Second buffer selected
        logic [PAGE_W-1:0] page; // Target page
        logic fail; // Failure flag
        logic [7:0] mem_q; // Inspection read data
    } pbp_dev_st_t;

    pbp_dev_st_t q; // Current state
    pbp_dev_st_t n; // Next state

    logic [7:0] mem [0:NPAGES*PAGE_BIG-1]; // Main array
    logic [7:0] bufm [0:2*PAGE_BIG-1]; // Both buffers, back to back
    logic buf_we; // Buffer write strobe
    logic [9:0] buf_wa; // Buffer write address
    logic [7:0] buf_wd; // Buffer write data
    logic mem_we; // Array write strobe
    logic [MAW-1:0] mem_wa; // Array write address
    logic [7:0] mem_wd; // Array write data

    // Opcode classes
    function automatic logic op_known(input logic [7:0] op);
        return op == OP_PGM_ERASE_B1 || op == OP_PGM_ERASE_B2 ||
            op == OP_PGM_B1 || op == OP_PGM_B2 ||
            op == OP_THRU_ERASE_B1 || op == OP_THRU_ERASE_B2 ||
            op == OP_THRU_B1;
    endfunction

    function automatic logic op_stream(input logic [7:0] op);
        return op == OP_THRU_ERASE_B1 || op == OP_THRU_ERASE_B2 ||
            op == OP_THRU_B1;
    endfunction

    function automatic logic op_second(input logic [7:0] op);
        return op == OP_PGM_ERASE_B2 || op == OP_PGM_B2 ||
            op == OP_THRU_ERASE_B2;
    endfunction

    function automatic logic op_erase(input logic [7:0] op);
        return op == OP_PGM_ERASE_B1 || op == OP_PGM_ERASE_B2 ||
            op == OP_THRU_ERASE_B1 || op == OP_THRU_ERASE_B2;
    endfunction

    // Page field; its low bit differs by page mode but sits alike for every opcode
    function automatic logic [PAGE_W-1:0] page_of(input logic [23:0] a,
                                                 input logic bin);
        return bin ? a[PAGE_LSB_BIN +: PAGE_W] : a[PAGE_LSB_BIG +: PAGE_W];
    endfunction

    // Starting buffer byte; a default-mode offset past the end restarts
    function automatic logic [8:0] off_of(input logic [23:0] a,
                                          input logic bin);
        logic [8:0] o;
        o = bin ? {1'b0, a[7:0]} : a[8:0];
        if (!bin && o >= 9'(PAGE_BIG)) begin
            o = 9'h000;
        end
        return o;
    endfunction

    // Cycles left after the copy pass, never below one
    function automatic logic [31:0] rest_of(input int t, input int used);
        return (t > used) ? 32'(t - used) : 32'h00000001;
    endfunction

    logic sck_rise; // Filtered link clock rising
    logic cs_rise; // Filtered chip select rising
    logic cs_fall; // Filtered chip select falling
    logic [7:0] byte_in; // Byte completed at this link edge
    logic [8:0] lim; // Page size in current mode
    logic [7:0] mb; // Array byte under the copy pointer
    logic [7:0] bb; // Buffer byte under the copy pointer
    int tot; // Self-timed total for this operation

    // Next-state logic
    always_comb begin
        n = q;
        tot = 0;
        buf_we = 1'b0;
        buf_wa = 10'h000;
        buf_wd = 8'h00;
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = 8'h00;
        lim = PAGE_256 ? 9'(PAGE_BIN) : 9'(PAGE_BIG);
        // Three stages; a change counts once stages two and three agree
        n.sck_s = {q.sck_s[1:0], LINK.sck};
        n.cs_s = {q.cs_s[1:0], LINK.cs_n};
        n.si_s = {q.si_s[1:0], LINK.si};
        if (q.sck_s[1] == q.sck_s[2]) begin
            n.sck_l = q.sck_s[2];
        end
        if (q.cs_s[1] == q.cs_s[2]) begin
            n.cs_l = q.cs_s[2];
        end
        sck_rise = n.sck_l & ~q.sck_l;
        cs_rise = n.cs_l & ~q.cs_l;
        cs_fall = ~n.cs_l & q.cs_l;
        byte_in = {q.sh[6:0], q.si_s[2]};
        mb = mem[MAW'(int'(q.page) * PAGE_BIG + int'(q.idx))];
        bb = bufm[10'(int'(q.bsel) * PAGE_BIG + int'(q.idx))];
        n.mem_q = mem[MEM_ADDR];

        // Command receive
        if (cs_fall) begin
            n.rx = RX_OPC;
            n.bitc = 3'h0;
            n.abyte = 2'h0;
            n.nbytes = 10'h000;
        end else if (cs_rise) begin
            n.rx = RX_IDLE;
            // Busy device never gets here with a live command
            if (q.rx == RX_HOLD ||
                (q.rx == RX_DATA && (q.opc != OP_THRU_B1 ||
                 (q.bitc == 3'h0 && q.nbytes != 10'h000)))) begin
                n.run = RUN_COPY;
                n.idx = 9'h000;
                n.page = page_of(q.addr, PAGE_256);
                n.erase = op_erase(q.opc);
                n.partial = (q.opc == OP_THRU_B1);
                n.bsel = op_second(q.opc);
                n.fail = 1'b0;
            end
        end else if (sck_rise && !q.cs_l && q.rx != RX_IDLE) begin
            n.sh = byte_in;
            n.bitc = q.bitc + 3'h1;
            if (q.bitc == 3'h7) begin
                unique case (q.rx)
                    RX_OPC: begin
                        n.opc = byte_in;
                        // Commands during busy are dropped
                        n.rx = (op_known(byte_in) && q.run == RUN_IDLE)
                            ? RX_ADDR : RX_SKIP;
                    end
                    RX_ADDR: begin
                        n.addr = {q.addr[15:0], byte_in};
                        n.abyte = q.abyte + 2'h1;
                        if (q.abyte == 2'(ADDR_BYTES - 1)) begin
                            n.rx = op_stream(q.opc) ? RX_DATA : RX_HOLD;
                            n.boff = off_of(n.addr, PAGE_256);
                            n.wmask = '0;
                        end
                    end
                    RX_DATA: begin
                        buf_we = 1'b1;
                        buf_wa = 10'(int'(op_second(q.opc)) * PAGE_BIG +
                                      int'(q.boff));
                        buf_wd = byte_in;
                        n.wmask[q.boff] = 1'b1;
                        n.boff = (q.boff == lim - 9'h001) ? 9'h000
                            : q.boff + 9'h001;
                        if (q.nbytes != 10'h3ff) begin
                            n.nbytes = q.nbytes + 10'h001;
                        end
                    end
                    RX_HOLD, RX_SKIP, RX_IDLE: begin
                        // Surplus bytes are ignored
                    end
                endcase
            end
        end

        // Internal operation: one byte per cycle, then the timed wait
        unique case (q.run)
            RUN_IDLE: begin
            end
            RUN_COPY: begin
                if (!q.partial || q.wmask[q.idx]) begin
                    mem_we = 1'b1;
                    mem_wa = MAW'(int'(q.page) * PAGE_BIG + int'(q.idx));
                    // Erased byte reads all ones, so erase+program is copy
                    mem_wd = q.erase ? bb : (mb & bb);
                    if (!q.erase && ((mb & bb) != bb)) begin
                        n.fail = 1'b1;
                    end
                end
                n.idx = q.idx + 9'h001;
                if (q.idx == lim - 9'h001) begin
                    n.run = RUN_WAIT;
                    if (q.erase) begin
                        tot = EP_CYCLES;
                    end else if (q.partial) begin
                        tot = int'(q.nbytes) * BP_CYCLES;
                        if (tot > P_CYCLES) begin
                            tot = P_CYCLES;
                        end
                    end else begin
                        tot = P_CYCLES;
                    end
                    n.wait_c = rest_of(tot, int'(lim));
                end
            end
            RUN_WAIT: begin
                n.wait_c = q.wait_c - 32'h00000001;
                if (q.wait_c <= 32'h00000001) begin
                    n.run = RUN_IDLE;
                end
            end
            default: n.run = RUN_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
            q.sck_s <= 3'h0;
            q.cs_s <= 3'h7;
            q.cs_l <= 1'b1;
            q.rx <= RX_IDLE;
            q.run <= RUN_IDLE;
        end else begin
            q <= n;
        end
    end

    // Storage arrays carry no reset
    always_ff @(posedge CLK) begin
        if (buf_we) begin
            bufm[buf_wa] <= buf_wd;
        end
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Outputs from the state register
    assign BUSY = (q.run != RUN_IDLE);
    assign FAIL = q.fail;
    assign MEM_DATA = q.mem_q;
    assign LINK.rdy = ~BUSY;
    assign LINK.fail = q.fail;
endmodule

//--- pbp_pkg.sv
// Shared constants and types for the buffer page-program sequencer
package pbp_pkg;
    // Command opcodes
    localparam logic [7:0] OP_PGM_ERASE_B1 = 8'h83; // Buffer 1 to page, erase
    localparam logic [7:0] OP_PGM_ERASE_B2 = 8'h86; // Buffer 2 to page, erase
    localparam logic [7:0] OP_PGM_B1 = 8'h88; // Buffer 1 to page, no erase
    localparam logic [7:0] OP_PGM_B2 = 8'h89; // Buffer 2 to page, no erase
    localparam logic [7:0] OP_THRU_ERASE_B1 = 8'h82; // Stream via buffer 1
    localparam logic [7:0] OP_THRU_ERASE_B2 = 8'h85; // Stream via buffer 2
    localparam logic [7:0] OP_THRU_B1 = 8'h02; // Stream, partial program
    // Page geometry
    localparam int PAGE_BIG = 264; // Bytes per page, default mode
    localparam int PAGE_BIN = 256; // Bytes per page, binary mode
    localparam int PAGES = 2048; // Pages in the array
    localparam int PAGE_W = 11; // Page number width
    localparam int PAGE_LSB_BIG = 9; // Page field low bit, default mode
    localparam int PAGE_LSB_BIN = 8; // Page field low bit, binary mode
    localparam int ADDR_BYTES = 3; // Address bytes after the opcode
    // Timing, maximum figures in microseconds
    localparam int CLK_MHZ = 20; // CLK rate
    localparam int ERASE_PROGRAM_TIME_US = 20000; // Plain default
    localparam int PAGE_PROGRAM_TIME_US = 3000; // Plain default
    localparam int BYTE_PROGRAM_TIME_US = 10; // Plain default
    // Longest times round down to whole cycles
    localparam int EP_CYC = ERASE_PROGRAM_TIME_US * CLK_MHZ;
    localparam int P_CYC = PAGE_PROGRAM_TIME_US * CLK_MHZ;
    localparam int BP_CYC = BYTE_PROGRAM_TIME_US * CLK_MHZ;
    // Host side link clock divider, half period in CLK cycles
    localparam int SCK_HALF_CYC = 4;
    // Host register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    // Host register fields
    localparam int CTRL_START_BIT = 8; // Send opcode plus address
    localparam int CTRL_END_BIT = 9; // Release chip select
    localparam int STAT_BUSY_BIT = 0; // Device busy
    localparam int STAT_FAIL_BIT = 1; // Erase/program failure
    localparam int STAT_OPEN_BIT = 2; // Chip select held low
    localparam logic [23:0] ADDR_RST = 24'h000000; // Address reset value
    // State encodings
    typedef enum logic [2:0] {
        RX_IDLE, RX_OPC, RX_ADDR, RX_DATA, RX_HOLD, RX_SKIP
    } pbp_rx_t;
    typedef enum logic [1:0] {RUN_IDLE, RUN_COPY, RUN_WAIT} pbp_run_t;
    typedef enum logic [1:0] {AC_IDLE, AC_SEND, AC_DONE} pbp_ac_t;
endpackage

//--- pbp_link_if.sv
`timescale 1ns/10ps
// Serial link between host and flash sequencer
interface pbp_link_if;
    logic sck; // Serial clock, made by the host
    logic cs_n; // Chip select, active low
    logic si; // Serial data into the device
    logic rdy; // Device ready, low while busy
    logic fail; // Erase/program failure flag
    modport dev (input sck, input cs_n, input si, output rdy, output fail);
    modport host (output sck, output cs_n, output si, input rdy, input fail);
endinterface

//--- pbp_host.sv
`timescale 1ns/10ps
// Host end: APB registers drive the serial link
module pbp_host
    import pbp_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial link
    pbp_link_if.host LINK
);
    // Whole state of the host end
    typedef struct packed {
        logic [2:0] rdy_s; // Ready synchroniser
        logic [2:0] fail_s; // Failure synchroniser
        logic rdy_l; // Filtered ready
        logic fail_l; // Filtered failure
        pbp_ac_t ac; // Transfer phase
        logic cs_n; // Chip select pin
        logic sck; // Serial clock pin
        logic si; // Serial data pin
        logic [7:0] div; // Half period divider
        logic [31:0] tx; // Outgoing bits, msb first
        logic [5:0] bits; // Bits still to send
        logic [23:0] addr; // Address bytes to send
        logic [31:0] prdata; // Read data
    } pbp_host_st_t;

    pbp_host_st_t q; // Current state
    pbp_host_st_t n; // Next state

    logic acc; // APB access phase
    logic wr_start; // Write that starts a shift
    logic mapped; // Address decodes

    // Next-state logic
    always_comb begin
        n = q;
        acc = PSEL & PENABLE;
        mapped = PADDR == REG_CTRL || PADDR == REG_ADDR ||
            PADDR == REG_DATA || PADDR == REG_STAT;
        wr_start = PWRITE && ((PADDR == REG_CTRL &&
            PWDATA[CTRL_START_BIT]) || PADDR == REG_DATA);
        n.rdy_s = {q.rdy_s[1:0], LINK.rdy};
        n.fail_s = {q.fail_s[1:0], LINK.fail};
        if (q.rdy_s[1] == q.rdy_s[2]) begin
            n.rdy_l = q.rdy_s[2];
        end
        if (q.fail_s[1] == q.fail_s[2]) begin
            n.fail_l = q.fail_s[2];
        end
        // Latch read data in the setup cycle
        if (PSEL && !PENABLE && !PWRITE) begin
            n.prdata = 32'h00000000;
            if (PADDR == REG_ADDR) begin
                n.prdata = {8'h00, q.addr};
            end else if (PADDR == REG_STAT) begin
                n.prdata[STAT_BUSY_BIT] = ~q.rdy_l;
                n.prdata[STAT_FAIL_BIT] = q.fail_l;
                n.prdata[STAT_OPEN_BIT] = ~q.cs_n;
            end
        end
        unique case (q.ac)
            AC_IDLE: begin
                if (acc && PWRITE) begin
                    if (PADDR == REG_ADDR) begin
                        n.addr = PWDATA[23:0];
                    end else if (wr_start && PADDR == REG_CTRL) begin
                        // Opcode then three address bytes
                        n.tx = {PWDATA[7:0], q.addr};
                        n.bits = 6'd32;
                        n.si = PWDATA[7];
                        n.cs_n = 1'b0;
                        n.div = 8'h00;
                        n.ac = AC_SEND;
                    end else if (wr_start) begin
                        // Only whole bytes leave here; pre-erase is ours
                        n.tx = {PWDATA[7:0], 24'h000000};
                        n.bits = 6'd8;
                        n.si = PWDATA[7];
                        n.cs_n = 1'b0;
                        n.div = 8'h00;
                        n.ac = AC_SEND;
                    end else if (PADDR == REG_CTRL &&
                                 PWDATA[CTRL_END_BIT]) begin
                        n.cs_n = 1'b1;
                    end
                end
            end
            AC_SEND: begin
                n.div = q.div + 8'h01;
                if (q.div == 8'(SCK_HALF - 1)) begin
                    n.div = 8'h00;
                    n.sck = ~q.sck;
                    // Data changes on the falling edge, sampled on rising
                    if (q.sck) begin
                        n.tx = {q.tx[30:0], 1'b0};
                        n.si = q.tx[30];
                        n.bits = q.bits - 6'd1;
                        if (q.bits == 6'd1) begin
                            n.ac = AC_DONE;
                        end
                    end
                end
            end
            AC_DONE: begin
                if (acc) begin
                    n.ac = AC_IDLE;
                end
            end
            default: n.ac = AC_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
            q.rdy_s <= 3'h7;
            q.rdy_l <= 1'b1;
            q.ac <= AC_IDLE;
            q.cs_n <= 1'b1;
            q.addr <= ADDR_RST;
        end else begin
            q <= n;
        end
    end

    // Shifting writes stall the bus until the last bit is out
    assign PREADY = (q.ac == AC_DONE) ||
        (q.ac == AC_IDLE && !(acc && wr_start));
    assign PSLVERR = acc && PREADY && !mapped;
    assign PRDATA = q.prdata;
    assign LINK.cs_n = q.cs_n;
    assign LINK.sck = q.sck;
    assign LINK.si = q.si;
endmodule

//--- pbp_checker.sv
`timescale 1ns/10ps
// Link watcher: framing, busy length and failure flag
module pbp_checker
    import pbp_pkg::*;
#(
    parameter int EP_CYCLES = 400,
    parameter int P_CYCLES = 300
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic rdy,
    input wire logic fail
);
    logic sck_q; // Link clock, last sample
    logic got_r; // Opcode byte complete
    logic [2:0] bits_r; // Bits in frame, mod 8
    logic [7:0] sh_r; // Bit shifter
    logic [7:0] opc_r; // Last opcode on the link
    logic [15:0] busy_r; // Cycles with rdy low
    logic [4:0] since_r; // Cycles since select rise
    logic ers; // Opcode carries built-in erase
    assign ers = opc_r inside {8'h82, 8'h83, 8'h85, 8'h86};
    // Decode what the device sees; sampled like the device, on CLK
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sck_q <= 1'b0;
            got_r <= 1'b0;
            bits_r <= 3'h0;
            sh_r <= 8'h00;
            opc_r <= 8'h00;
            busy_r <= 16'h0000;
            since_r <= 5'h1f;
        end else begin
            sck_q <= sck;
            if (cs_n) begin
                bits_r <= 3'h0;
                got_r <= 1'b0;
            end else if (sck && !sck_q) begin
                bits_r <= bits_r + 3'h1;
                sh_r <= {sh_r[6:0], si};
                if (bits_r == 3'h7 && !got_r) begin
                    opc_r <= {sh_r[6:0], si};
                    got_r <= 1'b1;
                end
            end
            busy_r <= rdy ? 16'h0000 : busy_r + 16'h0001;
            // Saturate so a long idle never looks like a fresh rise
            if ($rose(cs_n))
                since_r <= 5'h00;
            else if (since_r != 5'h1f)
                since_r <= since_r + 5'h01;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    idle_sck_a: assert property (cs_n |-> !sck)
        else $error("Link clock high while deselected");
    si_stable_a: assert property (sck && $past(sck) |-> $stable(si))
        else $error("Data moved while link clock high");
    byte_edge_a: assert property ($rose(cs_n) |-> bits_r == 3'h0)
        else $error("Select rose off a byte boundary");
    busy_cause_a: assert property ($fell(rdy) |-> since_r < 5'd12)
        else $error("Busy began without a select rise");
    ep_busy_a: assert property ($rose(rdy) && opc_r inside {8'h83, 8'h86}
        |-> busy_r >= EP_CYCLES - 3 && busy_r <= EP_CYCLES + 3)
        else $error("Erase-program busy length wrong");
    thru_busy_a: assert property ($rose(rdy) && opc_r inside {8'h82, 8'h85}
        |-> busy_r >= EP_CYCLES - 3 && busy_r <= EP_CYCLES + 3)
        else $error("Stream erase-program busy length wrong");
    pgm_busy_a: assert property ($rose(rdy) && opc_r inside {8'h88, 8'h89}
        |-> busy_r >= P_CYCLES - 3 && busy_r <= P_CYCLES + 3)
        else $error("Program busy length wrong");
    part_busy_a: assert property ($rose(rdy) && opc_r == 8'h02
        |-> busy_r <= P_CYCLES + 3)
        else $error("Partial program busy too long");
    erase_fail_a: assert property ($rose(rdy) && ers |-> !fail)
        else $error("Failure after erase-program");
    fail_in_op_a: assert property ($rose(fail)
        |-> !$past(rdy) || !$past(rdy, 2))
        else $error("Failure flag rose outside an operation");
    cover property ($rose(rdy) && opc_r == 8'h02);
    cover property ($rose(rdy) && opc_r == 8'h86);
    cover property ($rose(fail));
endmodule

//--- buffer_page_program_cmds_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    failures++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
// Host and device joined over the link
module buffer_page_program_cmds_tb
    import pbp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic page_256 = 1'b0; // Binary page mode
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, perr, dev_busy, dev_fail, busy2;
    logic [12:0] mem_addr = 13'h0000; // Array peek, stride 264
    logic [7:0] mem_data;
    logic [7:0] dq[$]; // Bytes for the next command
    int offs[4] = '{0, 1, 262, 263}; // Edges of a page, wrap points
    int failures = 0;
    int cmp_count = 0;
    pbp_link_if link();
    pbp_link_if lk2(); // Second link, driven raw to break framing
    always #25 clk = ~clk;
    pbp_host u_pbp_host (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LINK(link.host));
    // Short busy times, matching the checker's defaults
    pbp_dev #(.NPAGES(16), .EP_CYCLES(400), .P_CYCLES(300))
        u_pbp_dev (.CLK(clk), .RST_N(rst_n), .LINK(link.dev),
        .PAGE_256(page_256), .MEM_ADDR(mem_addr), .MEM_DATA(mem_data),
        .BUSY(dev_busy), .FAIL(dev_fail));
    pbp_dev #(.NPAGES(16)) u_pbp_dev_b (.CLK(clk), .RST_N(rst_n),
        .LINK(lk2.dev), .PAGE_256(page_256), .MEM_ADDR(mem_addr),
        .MEM_DATA(), .BUSY(busy2), .FAIL());
    pbp_checker u_pbp_checker (
        .CLK(clk), .RST_N(rst_n), .sck(link.sck), .cs_n(link.cs_n),
        .si(link.si), .rdy(link.rdy), .fail(link.fail));
    // Expected buffer contents after the two fills
    function automatic logic [7:0] fb1(input int o);
        return 8'((o + 2) % 264) ^ 8'h5a;
    endfunction
    function automatic logic [7:0] gb2(input int o);
        return 8'(o * 3);
    endfunction
    // One APB transfer; holds until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Command, then poll until idle
    task automatic cmd(input logic [7:0] op, input logic [23:0] ad);
        logic [31:0] q;
        apb(1'b1, REG_ADDR, {8'h00, ad}, q);
        apb(1'b1, REG_CTRL, {24'h000001, op}, q);
        foreach (dq[i]) apb(1'b1, REG_DATA, {24'h000000, dq[i]}, q);
        apb(1'b1, REG_CTRL, 32'h00000200, q);
        dq.delete();
        while (dev_busy !== 1'b1) @(posedge clk);
        do apb(1'b0, REG_STAT, 32'h0, q);
        while (q[STAT_BUSY_BIT] !== 1'b0 || dev_busy);
    endtask
    task automatic mchk(input int pg, input int o, input logic [7:0] e);
        mem_addr <= 13'(pg * 264 + o);
        repeat (3) @(posedge clk);
        `CHK(mem_data, e)
    endtask
    task automatic fchk(input logic e);
        logic [31:0] q;
        apb(1'b0, REG_STAT, 32'h0, q);
        `CHK(q[STAT_FAIL_BIT], e)
    endtask
    // Raw bits on the second link, 400 ns link clock
    task automatic bb(input logic [7:0] b, input int nb);
        for (int k = 0; k < nb; k++) begin
            lk2.sck <= 1'b0;
            lk2.si <= b[7-k];
            repeat (4) @(posedge clk);
            lk2.sck <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
    // One-byte 02 frame plus stray bits
    task automatic frame(input int extra);
        logic seen;
        seen = 1'b0;
        lk2.cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        bb(OP_THRU_B1, 8);
        bb(8'h00, 8);
        bb(8'h02, 8);
        bb(8'h00, 8);
        bb(8'h77, 8);
        bb(8'h00, extra);
        lk2.sck <= 1'b0;
        repeat (4) @(posedge clk);
        lk2.cs_n <= 1'b1;
        lk2.si <= ~lk2.si;
        repeat (40) @(posedge clk) seen |= busy2;
        `CHK(seen, extra == 0)
    endtask
    task automatic wrap_up();
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog, about twice the run
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        wrap_up();
    end
    initial begin
        lk2.cs_n = 1'b1;
        lk2.sck = 1'b0;
        lk2.si = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h10, 32'h0, rd);
        `CHK(perr, 1'b1)
        for (int i = 0; i < 264; i++) dq.push_back(8'(i) ^ 8'h5a);
        cmd(OP_THRU_ERASE_B1, {4'h0, 11'd3, 9'd262});
        foreach (offs[j]) mchk(3, offs[j], fb1(offs[j]));
        for (int i = 0; i < 264; i++) dq.push_back(gb2(i));
        cmd(OP_THRU_ERASE_B2, {4'h0, 11'd4, 9'd0});
        foreach (offs[j]) mchk(4, offs[j], gb2(offs[j]));
        cmd(OP_PGM_ERASE_B1, {4'h0, 11'd6, 9'd0});
        foreach (offs[j]) mchk(6, offs[j], fb1(offs[j]));
        cmd(OP_PGM_ERASE_B2, {4'h0, 11'd7, 9'd0});
        foreach (offs[j]) mchk(7, offs[j], gb2(offs[j]));
        cmd(OP_PGM_B1, {4'h0, 11'd6, 9'd0});
        fchk(1'b0);
        cmd(OP_PGM_B2, {4'h0, 11'd6, 9'd0});
        fchk(1'b1);
        `CHK(dev_fail, 1'b1)
        foreach (offs[j]) mchk(6, offs[j], fb1(offs[j]) & gb2(offs[j]));
        dq = '{8'hf0, 8'h0f};
        cmd(OP_THRU_B1, {4'h0, 11'd7, 9'd5});
        mchk(7, 5, gb2(5) & 8'hf0);
        mchk(7, 6, gb2(6) & 8'h0f);
        mchk(7, 7, gb2(7));
        page_256 <= 1'b1;
        dq = '{8'h3c, 8'hc3};
        cmd(OP_THRU_ERASE_B1, {5'h00, 11'd9, 8'hff});
        mchk(9, 255, 8'h3c);
        mchk(9, 0, 8'hc3);
        cmd(OP_PGM_ERASE_B1, {5'h00, 11'd10, 8'h00});
        mchk(10, 255, 8'h3c);
        cmd(OP_PGM_B1, {5'h00, 11'd10, 8'h00});
        fchk(1'b0);
        dq = '{8'h0f};
        cmd(OP_THRU_B1, {5'h00, 11'd9, 8'h00});
        mchk(9, 0, 8'h03);
        mchk(9, 255, 8'h3c);
        page_256 <= 1'b0;
        frame(3);
        frame(0);
        wrap_up();
    end
endmodule
